// ### logic/dpim_meter.sv
// Notes on behaviour
// (R1) Accept level only after stable debounce interval
// (R2) Debounce in ms, multiples of ten, 0-1000
// (R3) Normal mode counts pulses, flags alarm event
// (R4) Demand-sync mode pulses resync demand period
// (R5) Metering mode routes pulses to assigned channel
// (R6) Tariff mode drives tariff selection, no metering
// (R7) Channel counts pulses from all assigned inputs
// (R8) Pulse mode counts complete on-off cycles
// (R9) Transition mode counts every state change
// (R10) Pulse weight ranges 0 to 99.99999
// (R11) Consumption equals count divided by weight
// (R12) Unit selector: none, energy, volume, mass, heat
// (R13) Energy units force matching power demand code
// (R14) Other units select per-hour or per-second rate
// (R15) Up to four inputs; last two optional
// (R16) Stable interval timed by 1 ms tick
// (R17) Reset clears levels, counters; functions normal
module dpim_meter import dpim_pkg::*; #(
   parameter int MS_TICK_CYCLES = DPIM_TICK_CYCLES,
   parameter int NUM_CH = 2,
   parameter int INPUTS_PRESENT = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic discrete_input_one,
   input wire logic discrete_input_two,
   input wire logic discrete_input_three,
   input wire logic discrete_input_four,
   output logic [DPIM_NUM_IN-1:0] input_alarm,
   output logic demand_sync,
   output logic [DPIM_NUM_IN-1:0] tariff_select
);
   localparam int TW = $clog2(MS_TICK_CYCLES + 1);
   localparam logic [DPIM_NUM_IN-1:0] PRESENT = DPIM_NUM_IN'((1 << INPUTS_PRESENT) - 1);

   logic [DPIM_NUM_IN-1:0] raw;
   logic [TW-1:0] tick_cnt_reg;
   logic tick_reg;
   dpim_evt_type evt;
   dpim_evt_type ch_evt;
   dpim_func_type fn_reg [DPIM_NUM_IN];
   logic [9:0] deb_reg [DPIM_NUM_IN];
   logic [31:0] norm_cnt_reg [DPIM_NUM_IN];
   logic [DPIM_NUM_IN-1:0] norm_m, dsync_m, meter_m, tariff_m;
   logic [DPIM_NUM_IN-1:0] input_alarm_reg, tariff_reg;
   logic demand_sync_reg;
   logic ch_mode_reg [NUM_CH];
   logic [DPIM_NUM_IN-1:0] ch_mask_reg [NUM_CH];
   logic [4:0] ch_unit_reg [NUM_CH];
   logic ch_rate_reg [NUM_CH];
   logic [23:0] ch_weight_reg [NUM_CH];
   logic [31:0] ch_count [NUM_CH];
   logic [31:0] ch_qty [NUM_CH];
   logic [31:0] rd_val;
   logic hit, wr_bad, wr_func;
   logic [DPIM_NUM_IN-1:0] wr_deb;
   logic [NUM_CH-1:0] wr_cfg, wr_weight;
   logic [31:0] prdata_reg;
   logic ack_reg, err_reg, wr_en;

   // Absent inputs on smaller variants are held off before the filter
   assign raw = {discrete_input_four, discrete_input_three,
                 discrete_input_two, discrete_input_one} & PRESENT; // [R15]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == TW'(MS_TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0; // [R16]
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TW'(1);
         tick_reg <= 1'b0;
      end
   end

   for (genvar gi = 0; gi < DPIM_NUM_IN; gi++) begin : g_in
      dpim_debounce u_deb (
         .pclk(pclk),
         .presetn(presetn),
         .raw(raw[gi]),
         .tick(tick_reg),
         .interval_ms(deb_reg[gi]),
         .level_reg(evt.level[gi]),
         .rise_reg(evt.rise[gi]),
         .fall_reg(evt.fall[gi])
      );
   end

   always_comb begin
      for (int i = 0; i < DPIM_NUM_IN; i++) begin
         norm_m[i] = fn_reg[i] == DPIM_FN_NORMAL;
         dsync_m[i] = fn_reg[i] == DPIM_FN_DSYNC;
         meter_m[i] = fn_reg[i] == DPIM_FN_METER;
         tariff_m[i] = fn_reg[i] == DPIM_FN_TARIFF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DPIM_NUM_IN; i++) norm_cnt_reg[i] <= 32'h0;
      end else begin
         for (int i = 0; i < DPIM_NUM_IN; i++) begin
            if (evt.rise[i] && norm_m[i]) norm_cnt_reg[i] <= norm_cnt_reg[i] + 32'h1; // [R3]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_alarm_reg <= '0;
         demand_sync_reg <= 1'b0;
         tariff_reg <= '0;
      end else begin
         input_alarm_reg <= evt.rise & norm_m; // [R3]
         demand_sync_reg <= |(evt.rise & dsync_m); // [R4]
         tariff_reg <= evt.level & tariff_m; // [R6]
      end
   end

   assign input_alarm = input_alarm_reg;
   assign demand_sync = demand_sync_reg;
   assign tariff_select = tariff_reg;

   // Only inputs in metering mode reach the channels
   assign ch_evt = '{rise: evt.rise & meter_m, fall: evt.fall & meter_m,
                     level: evt.level & meter_m}; // [R5]

   for (genvar gc = 0; gc < NUM_CH; gc++) begin : g_ch
      dpim_channel u_ch (
         .pclk(pclk),
         .presetn(presetn),
         .evt(ch_evt),
         .route_mask(ch_mask_reg[gc]),
         .trans_mode(ch_mode_reg[gc]),
         .weight(ch_weight_reg[gc]),
         .count_reg(ch_count[gc]),
         .qty_reg(ch_qty[gc])
      );
   end

   // Address decode, read mux and write legality in one place
   always_comb begin
      rd_val = 32'h0;
      hit = 1'b0;
      wr_bad = 1'b0;
      wr_func = 1'b0;
      wr_deb = '0;
      wr_cfg = '0;
      wr_weight = '0;
      if (paddr == DPIM_OFF_FUNC) begin
         hit = 1'b1;
         wr_func = 1'b1;
         for (int i = 0; i < DPIM_NUM_IN; i++) rd_val[2*i +: 2] = fn_reg[i];
      end
      if (paddr == DPIM_OFF_STATUS) begin
         hit = 1'b1;
         rd_val[DPIM_NUM_IN-1:0] = evt.level;
      end
      for (int i = 0; i < DPIM_NUM_IN; i++) begin
         if (paddr == DPIM_OFF_DEB + 12'(i) * DPIM_WORD) begin
            hit = 1'b1;
            wr_deb[i] = 1'b1;
            rd_val[9:0] = deb_reg[i];
            wr_bad = pwdata[31:10] != 22'h0 || pwdata[9:0] > DPIM_DEB_MAX_MS
                     || (pwdata[9:0] % DPIM_DEB_STEP_MS) != 10'h0; // [R2]
         end
         if (paddr == DPIM_OFF_CNT + 12'(i) * DPIM_WORD) begin
            hit = 1'b1;
            rd_val = norm_cnt_reg[i];
         end
      end
      for (int c = 0; c < NUM_CH; c++) begin
         if (paddr == DPIM_OFF_CH + 12'(c) * DPIM_CH_STRIDE + {8'h0, DPIM_CH_CFG, 2'b00}) begin
            hit = 1'b1;
            wr_cfg[c] = 1'b1;
            rd_val[DPIM_CFG_MODE_BIT] = ch_mode_reg[c];
            rd_val[DPIM_CFG_MASK_LSB +: DPIM_NUM_IN] = ch_mask_reg[c];
            rd_val[DPIM_CFG_UNIT_LSB +: 5] = ch_unit_reg[c];
            rd_val[DPIM_CFG_RATE_BIT] = ch_rate_reg[c];
            rd_val[DPIM_CFG_DMD_LSB +: 3] = dpim_demand(ch_unit_reg[c], ch_rate_reg[c]); // [R13] [R14]
            wr_bad = pwdata[DPIM_CFG_UNIT_LSB +: 5] > DPIM_U_THERM; // [R12]
         end
         if (paddr == DPIM_OFF_CH + 12'(c) * DPIM_CH_STRIDE + {8'h0, DPIM_CH_WEIGHT, 2'b00}) begin
            hit = 1'b1;
            wr_weight[c] = 1'b1;
            rd_val[23:0] = ch_weight_reg[c];
            wr_bad = pwdata[31:24] != 8'h0 || pwdata[23:0] > DPIM_WEIGHT_MAX; // [R10]
         end
         if (paddr == DPIM_OFF_CH + 12'(c) * DPIM_CH_STRIDE + {8'h0, DPIM_CH_COUNT, 2'b00}) begin
            hit = 1'b1;
            rd_val = ch_count[c];
         end
         if (paddr == DPIM_OFF_CH + 12'(c) * DPIM_CH_STRIDE + {8'h0, DPIM_CH_QTY, 2'b00}) begin
            hit = 1'b1;
            rd_val = ch_qty[c];
         end
      end
   end

   // Data is captured in the setup cycle so prdata comes from a flop with no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         prdata_reg <= 32'h0;
      end else begin
         ack_reg <= psel & ~penable;
         if (psel && !penable) begin
            prdata_reg <= pwrite ? 32'h0 : rd_val;
            err_reg <= !hit || (pwrite && wr_bad);
         end
      end
   end

   assign pready = ack_reg;
   assign pslverr = ack_reg & err_reg;
   assign prdata = prdata_reg;
   assign wr_en = psel & penable & pwrite & ack_reg & ~err_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DPIM_NUM_IN; i++) begin
            fn_reg[i] <= DPIM_FN_NORMAL; // [R17]
            deb_reg[i] <= 10'h0;
         end
      end else if (wr_en) begin
         for (int i = 0; i < DPIM_NUM_IN; i++) begin
            if (wr_func) fn_reg[i] <= dpim_func_type'(pwdata[2*i +: 2]);
            if (wr_deb[i]) deb_reg[i] <= pwdata[9:0]; // [R2]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NUM_CH; c++) begin
            ch_mode_reg[c] <= 1'b0;
            ch_mask_reg[c] <= '0;
            ch_unit_reg[c] <= DPIM_U_NONE;
            ch_rate_reg[c] <= 1'b0;
            ch_weight_reg[c] <= 24'h0;
         end
      end else if (wr_en) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (wr_cfg[c]) begin
               ch_mode_reg[c] <= pwdata[DPIM_CFG_MODE_BIT];
               ch_mask_reg[c] <= pwdata[DPIM_CFG_MASK_LSB +: DPIM_NUM_IN] & PRESENT; // [R15]
               ch_unit_reg[c] <= pwdata[DPIM_CFG_UNIT_LSB +: 5]; // [R12]
               ch_rate_reg[c] <= pwdata[DPIM_CFG_RATE_BIT]; // [R14]
            end
            if (wr_weight[c]) ch_weight_reg[c] <= pwdata[23:0]; // [R10]
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_tick_spacing: assert property (tick_reg |=> !tick_reg [*8]) // [R16]
      else $error("Millisecond tick repeats too soon");
   a_deb_reject: assert property (psel && !penable && pwrite && wr_deb != '0 && wr_bad
         |=> pslverr ##1 deb_reg[0] == $past(deb_reg[0], 2)) // [R2]
      else $error("Illegal debounce write not refused");
   a_normal_count: assert property (evt.rise[0] && norm_m[0]
         |=> norm_cnt_reg[0] == $past(norm_cnt_reg[0]) + 32'h1) // [R3]
      else $error("Normal mode pulse not counted");
   a_dsync_pulse: assert property ((evt.rise & dsync_m) != '0 |=> demand_sync) // [R4]
      else $error("Demand sync pulse missing");
   a_route_meter: assert property ($changed(ch_count[0]) |-> $past(|(ch_evt.rise | ch_evt.fall))) // [R5]
      else $error("Channel counted a non-metering input");
   a_tariff_level: assert property (tariff_m[1] |=> tariff_select[1] == $past(evt.level[1])) // [R6]
      else $error("Tariff select not following input");
   a_demand_energy: assert property (ch_unit_reg[0] inside {DPIM_U_WH, DPIM_U_KWH, DPIM_U_MWH}
         |-> dpim_demand(ch_unit_reg[0], ch_rate_reg[0]) == DPIM_DM_KW) // [R13]
      else $error("Energy unit without kW demand");
   a_rate_select: assert property (ch_unit_reg[0] > DPIM_U_MVAH && ch_rate_reg[0]
         |-> dpim_demand(ch_unit_reg[0], ch_rate_reg[0]) == DPIM_DM_PER_SEC) // [R14]
      else $error("Rate per second not selected");
   a_weight_limit: assert property (ch_weight_reg[0] <= DPIM_WEIGHT_MAX) // [R10]
      else $error("Pulse weight above limit");
   a_unit_legal: assert property (ch_unit_reg[0] <= DPIM_U_THERM) // [R12]
      else $error("Unit code out of range");
   a_absent_inputs: assert property ((evt.level & ~PRESENT) == '0) // [R15]
      else $error("Absent input shows a level");
   a_reset_clear: assert property (disable iff (1'b0) !presetn |-> evt.level == '0
         && norm_cnt_reg[0] == 32'h0 && fn_reg[0] == DPIM_FN_NORMAL) // [R17]
      else $error("Reset state not cleared");
   c_alarm: cover property (input_alarm != '0);
   c_dsync: cover property (demand_sync);
   c_chan: cover property ($changed(ch_count[0]));
   c_err: cover property (pslverr);
endmodule

// ### pkg/dpim_pkg.sv
package dpim_pkg;
   localparam int DPIM_NUM_IN = 4;
   localparam int DPIM_CLK_PERIOD_NS = 4;
   localparam int DPIM_TICK_PERIOD_NS = 1000000;
   localparam int DPIM_TICK_CYCLES = DPIM_TICK_PERIOD_NS / DPIM_CLK_PERIOD_NS;
   localparam logic [9:0] DPIM_DEB_MAX_MS = 10'h3e8;
   localparam logic [9:0] DPIM_DEB_STEP_MS = 10'h00a;
   // Pulse weight is held in units of 1e-5, so 99.99999 is 9999999
   localparam logic [23:0] DPIM_WEIGHT_MAX = 24'h98967f;
   localparam logic [23:0] DPIM_WEIGHT_SCALE = 24'h0186a0;
   localparam logic [11:0] DPIM_OFF_FUNC = 12'h000;
   localparam logic [11:0] DPIM_OFF_STATUS = 12'h004;
   localparam logic [11:0] DPIM_OFF_DEB = 12'h010;
   localparam logic [11:0] DPIM_OFF_CNT = 12'h020;
   localparam logic [11:0] DPIM_OFF_CH = 12'h040;
   localparam logic [11:0] DPIM_CH_STRIDE = 12'h010;
   localparam logic [11:0] DPIM_WORD = 12'h004;
   localparam logic [1:0] DPIM_CH_CFG = 2'h0;
   localparam logic [1:0] DPIM_CH_WEIGHT = 2'h1;
   localparam logic [1:0] DPIM_CH_COUNT = 2'h2;
   localparam logic [1:0] DPIM_CH_QTY = 2'h3;
   localparam int DPIM_CFG_MODE_BIT = 0;
   localparam int DPIM_CFG_MASK_LSB = 4;
   localparam int DPIM_CFG_UNIT_LSB = 8;
   localparam int DPIM_CFG_RATE_BIT = 16;
   localparam int DPIM_CFG_DMD_LSB = 20;

   typedef enum logic [1:0] {
      DPIM_FN_NORMAL = 2'h0,
      DPIM_FN_DSYNC = 2'h1,
      DPIM_FN_METER = 2'h2,
      DPIM_FN_TARIFF = 2'h3
   } dpim_func_type;

   typedef enum logic [4:0] {
      DPIM_U_NONE = 5'h00, DPIM_U_WH = 5'h01, DPIM_U_KWH = 5'h02, DPIM_U_MWH = 5'h03,
      DPIM_U_VARH = 5'h04, DPIM_U_KVARH = 5'h05, DPIM_U_MVARH = 5'h06,
      DPIM_U_VAH = 5'h07, DPIM_U_KVAH = 5'h08, DPIM_U_MVAH = 5'h09,
      DPIM_U_GAL = 5'h0a, DPIM_U_BTU = 5'h0b, DPIM_U_LITRE = 5'h0c, DPIM_U_M3 = 5'h0d,
      DPIM_U_MCF = 5'h0e, DPIM_U_LBS = 5'h0f, DPIM_U_KG = 5'h10, DPIM_U_KLBS = 5'h11,
      DPIM_U_THERM = 5'h12
   } dpim_unit_type;

   typedef enum logic [2:0] {
      DPIM_DM_NONE = 3'h0, DPIM_DM_KW = 3'h1, DPIM_DM_KVAR = 3'h2, DPIM_DM_KVA = 3'h3,
      DPIM_DM_PER_HOUR = 3'h4, DPIM_DM_PER_SEC = 3'h5
   } dpim_demand_type;

   typedef struct packed {
      logic [DPIM_NUM_IN-1:0] rise;
      logic [DPIM_NUM_IN-1:0] fall;
      logic [DPIM_NUM_IN-1:0] level;
   } dpim_evt_type;

   function automatic dpim_demand_type dpim_demand(input logic [4:0] unit, input logic per_sec);
      if (unit == DPIM_U_NONE) return DPIM_DM_NONE;
      if (unit <= DPIM_U_MWH) return DPIM_DM_KW;
      if (unit <= DPIM_U_MVARH) return DPIM_DM_KVAR;
      if (unit <= DPIM_U_MVAH) return DPIM_DM_KVA;
      return per_sec ? DPIM_DM_PER_SEC : DPIM_DM_PER_HOUR;
   endfunction

   function automatic logic [2:0] dpim_popcount(input logic [DPIM_NUM_IN-1:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < DPIM_NUM_IN; i++) n = n + 3'(v[i]);
      return n;
   endfunction
endpackage

// ### logic/dpim_debounce.sv
module dpim_debounce import dpim_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic raw,
   input wire logic tick,
   input wire logic [9:0] interval_ms,
   output logic level_reg,
   output logic rise_reg,
   output logic fall_reg
);
   logic sync1_reg;
   logic sync2_reg;
   logic cand_reg;
   logic [10:0] cnt_reg;
   logic ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= raw;
         sync2_reg <= sync1_reg;
      end
   end

   // Count is one above the interval because the first tick may land right after a change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cand_reg <= 1'b0;
         cnt_reg <= 11'h000;
      end else if (sync2_reg != cand_reg) begin
         cand_reg <= sync2_reg; // [R16]
         cnt_reg <= 11'h000;
      end else if (tick && cnt_reg <= {1'b0, DPIM_DEB_MAX_MS}) begin
         cnt_reg <= cnt_reg + 11'h001;
      end
   end

   assign ok = (interval_ms == 10'h000) || (cnt_reg > {1'b0, interval_ms});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 1'b0; // [R17]
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
         if (cand_reg == sync2_reg && cand_reg != level_reg && ok) begin
            level_reg <= cand_reg; // [R1]
            rise_reg <= cand_reg;
            fall_reg <= ~cand_reg;
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_level_hold: assert property ($changed(level_reg) |-> $past(ok)) // [R1]
      else $error("Level accepted before stable interval");
   a_edge_match: assert property (rise_reg |-> level_reg && $past(!level_reg)) // [R1]
      else $error("Rise without level change");
endmodule

// ### logic/dpim_channel.sv
module dpim_channel import dpim_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input dpim_evt_type evt,
   input wire logic [DPIM_NUM_IN-1:0] route_mask,
   input wire logic trans_mode,
   input wire logic [23:0] weight,
   output logic [31:0] count_reg,
   output logic [31:0] qty_reg
);
   logic [DPIM_NUM_IN-1:0] sel;
   logic [2:0] n;
   logic [25:0] res_reg;
   logic [25:0] res_sum;

   // Pulse mode waits for the falling edge, which closes a full on-off cycle
   assign sel = (trans_mode ? (evt.rise | evt.fall) : evt.fall) & route_mask; // [R8] [R9]
   assign n = dpim_popcount(sel); // [R7]
   assign res_sum = res_reg + 26'(n) * 26'(DPIM_WEIGHT_SCALE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) count_reg <= 32'h0; // [R17]
      else count_reg <= count_reg + 32'(n); // [R7]
   end

   // Quantity is count / weight, built by repeated subtraction; one unit per cycle
   // is far faster than any millisecond-scale pulse train
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_reg <= 26'h0;
         qty_reg <= 32'h0;
      end else if (weight == 24'h0) begin
         res_reg <= res_reg;
      end else if (res_sum >= {2'b00, weight}) begin
         res_reg <= res_sum - {2'b00, weight}; // [R11]
         qty_reg <= qty_reg + 32'h1;
      end else begin
         res_reg <= res_sum;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pulse_mode: assert property (!trans_mode && (evt.fall & route_mask) == '0 |=> $stable(count_reg)) // [R8]
      else $error("Pulse mode counted without a falling edge");
   a_trans_mode: assert property (trans_mode && (evt.rise & route_mask) != '0 |=> count_reg != $past(count_reg)) // [R9]
      else $error("Transition mode missed a rising edge");
   a_zero_weight: assert property (weight == 24'h0 |=> $stable(qty_reg)) // [R11]
      else $error("Quantity moved with zero weight");
   c_qty_step: cover property (qty_reg != $past(qty_reg));
endmodule

// ### tb/dpim_contact_model.sv
module dpim_contact_model (
   input wire logic pclk,
   output logic [3:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pins = 4'h0;
   // Contacts are always driven; the bursts of 1-cycle bounce must be dropped
   task automatic pulse(input int i, input int n);
      repeat (n) begin
         repeat (3) begin
            @(posedge pclk) pins[i] <= 1'b1;
            @(posedge pclk) pins[i] <= 1'b0;
         end
         @(posedge pclk) pins[i] <= 1'b1;
         repeat (150) @(posedge pclk);
         pins[i] <= 1'b0;
         repeat (150) @(posedge pclk);
      end
   endtask
   task automatic hold(input int i, input logic v);
      @(posedge pclk) pins[i] <= v;
      repeat (200) @(posedge pclk);
   endtask
endmodule

// ### tb/debounced_pulse_input_meter_tb_top.sv
module debounced_pulse_input_meter_tb_top;
   import dpim_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, demand_sync, er, rdy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pins, input_alarm, tariff_select;
   int failures, n_compared, n_alarm, n_sync, w0, n0, n1, n3, m0, r, dm;
   localparam logic [11:0] CH = DPIM_OFF_CH;

   dpim_meter #(.MS_TICK_CYCLES(10), .NUM_CH(2), .INPUTS_PRESENT(4)) dpim_meter_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .discrete_input_one(pins[0]), .discrete_input_two(pins[1]),
      .discrete_input_three(pins[2]), .discrete_input_four(pins[3]),
      .input_alarm(input_alarm), .demand_sync(demand_sync), .tariff_select(tariff_select));
   dpim_contact_model contact_inst (.pclk(pclk), .pins(pins));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (input_alarm[0] === 1'b1) n_alarm++;
      if (demand_sync === 1'b1) n_sync++;
   end

   task automatic results;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Master waits on pready; slave flops update only in the NBA region, so reading
   // right after the rising edge gives the values sampled at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         rdy = pready;
         rd = prdata;
         er = pslverr;
         k++;
      end while (rdy !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (rdy !== 1'b1) begin
         failures++;
         results();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk("pslverr", {31'h0, e}, {31'h0, er});
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("pslverr", 32'h0, {31'h0, er});
      chk($sformatf("reg %h", a), exp, rd);
   endtask

   function automatic int dcode(input int u, input int s);
      if (u == 0) return 0;
      if (u <= 3) return 1;
      if (u <= 6) return 2;
      if (u <= 9) return 3;
      return s ? 5 : 4;
   endfunction

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      presetn = 1'b0;
      failures = 0;
      n_compared = 0;
      n_alarm = 0;
      n_sync = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(80));
      rdc(DPIM_OFF_FUNC, 32'h0);
      rdc(DPIM_OFF_STATUS, 32'h0);
      rdc(DPIM_OFF_CNT, 32'h0);
      rdc(CH, 32'h0);
      $display("test reset done");
      wr(DPIM_OFF_DEB, 32'd1000, 1'b0);
      wr(DPIM_OFF_DEB, 32'd1005, 1'b1);
      wr(DPIM_OFF_DEB, 32'd1010, 1'b1);
      rdc(DPIM_OFF_DEB, 32'd1000);
      for (int i = 0; i < 4; i++) wr(DPIM_OFF_DEB + 12'(4 * i), 32'd10, 1'b0);
      wr(CH + 12'h004, 32'h0098967f, 1'b0);
      wr(CH + 12'h004, 32'h00989680, 1'b1);
      rdc(CH + 12'h004, 32'h0098967f);
      for (int u = 0; u < 20; u++) begin
         r = $urandom % 2;
         wr(CH, 32'(u << 8) | 32'(r << 16), u > 18);
         dm = dcode(u, r);
         if (u < 19) rdc(CH, 32'(u << 8) | 32'(r << 16) | 32'(dm << 20));
      end
      apb(1'b0, 12'hffc, 32'h0);
      chk("unmapped pslverr", 32'h1, {31'h0, er});
      $display("test registers done");
      w0 = 10000 + $urandom % 90000;
      n0 = 1 + $urandom % 4;
      n1 = 1 + $urandom % 4;
      n3 = 1 + $urandom % 4;
      m0 = 1 + $urandom % 3;
      wr(CH + 12'h004, 32'(w0), 1'b0);
      wr(CH, 32'h80, 1'b0);
      wr(CH + 12'h010, 32'h91, 1'b0);
      wr(DPIM_OFF_FUNC, 32'hb4, 1'b0);
      fork
         contact_inst.pulse(0, n0);
         contact_inst.pulse(1, n1);
         contact_inst.pulse(3, n3);
      join
      chk("alarm pulses", 32'(n0), 32'(n_alarm));
      rdc(DPIM_OFF_CNT, 32'(n0));
      rdc(DPIM_OFF_CNT + 12'h004, 32'h0);
      chk("sync pulses", 32'(n1), 32'(n_sync));
      rdc(CH + 12'h008, 32'(n3));
      rdc(CH + 12'h018, 32'(2 * n3));
      rdc(CH + 12'h00c, 32'((n3 * 100000) / w0));
      rdc(CH + 12'h01c, 32'h0);
      $display("test counting done");
      contact_inst.hold(2, 1'b1);
      chk("tariff", 32'h4, {28'h0, tariff_select});
      rdc(DPIM_OFF_STATUS, 32'h4);
      contact_inst.hold(2, 1'b0);
      chk("tariff", 32'h0, {28'h0, tariff_select});
      wr(DPIM_OFF_FUNC, 32'hb6, 1'b0);
      contact_inst.pulse(0, m0);
      rdc(CH + 12'h018, 32'(2 * (n3 + m0)));
      rdc(CH + 12'h008, 32'(n3));
      chk("alarm pulses", 32'(n0), 32'(n_alarm));
      $display("test routing done");
      results();
   end

   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      results();
   end
endmodule
